// ### design/spiu_controller.sv
// spiu_controller: seven-source, four-level nested interrupt controller with vector output
// assumes sources and core are synchronous to clk; the core acks the presented request
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module spiu_controller
  import spiu_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire spiu_bus_req_t busReq,
  output logic [7:0] busRdata,
  input wire spiu_events_t events,
  output spiu_core_req_t coreReq,
  input wire logic coreAck,
  input wire logic coreReti,
  output logic irqOut
);

  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] RESP_MIN = CNT_W'(RESP_MIN_CYC);

  typedef struct packed {
    logic [7:0] irqEnable;
    logic [6:0] prioLow;
    logic [6:0] prioHigh;
    logic [6:0] reqFlags;
    logic [1:0] extMode;
    logic [6:0] evtStatus;
    logic [6:0] evtMask;
    logic [7:0] acqSync;
    logic [6:0] dispSync;
    logic [3:0] inService;
    logic [1:0] pinPrev;
    logic [6:0] rawPrev;
    logic [CNT_W-1:0] delayCnt;
    logic [7:0] rdData;
    spiu_core_req_t present;
  } spiu_state_t;

  spiu_state_t state_reg;
  spiu_state_t state_next;

  logic [6:0] rawReq;
  logic [6:0] eligible;
  logic [1:0] srcLevel [NUM_SRC];
  logic candValid;
  logic [2:0] candSrc;
  logic [1:0] candLevel;
  logic svcActive;
  logic [1:0] svcLevel;
  logic syncReq;

  // sync group request from flag and enable pairs
  always_comb begin
    syncReq = 1'b0;
    for (int k = 0; k < 2; k++) begin
      syncReq = syncReq | (state_reg.dispSync[2*k] & state_reg.dispSync[2*k+1]);
    end
    for (int k = 0; k < 4; k++) begin
      syncReq = syncReq | (state_reg.acqSync[2*k] & state_reg.acqSync[2*k+1]);
    end
  end

  // per-source raw requests and the level currently in service
  always_comb begin
    rawReq[SRC_EXT0] = state_reg.reqFlags[FLG_EXT0];
    rawReq[SRC_TMR0] = state_reg.reqFlags[FLG_TMR0];
    rawReq[SRC_EXT1] = state_reg.reqFlags[FLG_EXT1];
    rawReq[SRC_TMR1] = state_reg.reqFlags[FLG_TMR1];
    rawReq[SRC_SER] = state_reg.reqFlags[FLG_RX] | state_reg.reqFlags[FLG_TX];
    rawReq[SRC_SYNC] = syncReq;
    rawReq[SRC_ADC] = state_reg.reqFlags[FLG_ADC];
    svcActive = |state_reg.inService;
    svcLevel = 2'd0;
    for (int l = 0; l < 4; l++) begin
      if (state_reg.inService[l]) begin
        svcLevel = 2'(l);
      end
    end
    for (int i = 0; i < NUM_SRC; i++) begin
      srcLevel[i] = {state_reg.prioHigh[i], state_reg.prioLow[i]};
    end
  end

  // pick the winner: highest level first, lowest source index inside a level
  always_comb begin
    candValid = 1'b0;
    candSrc = 3'd0;
    candLevel = 2'd0;
    for (int i = 0; i < NUM_SRC; i++) begin
      eligible[i] = rawReq[i] & state_reg.irqEnable[i]
        & state_reg.irqEnable[GLOBAL_EN_BIT]
        & (!svcActive || srcLevel[i] > svcLevel);
    end
    for (int l = 3; l >= 0; l--) begin
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (!candValid && eligible[i] && srcLevel[i] == 2'(l)) begin
          candSrc = 3'(i);
          candLevel = 2'(l);
        end
      end
      if (!candValid) begin
        for (int i = 0; i < NUM_SRC; i++) begin
          candValid = candValid | (eligible[i] && srcLevel[i] == 2'(l));
        end
      end
    end
  end

  // next state: register writes, hardware flag setting, service bookkeeping
  always_comb begin
    logic wrHit;
    logic takeAck;
    logic [6:0] hwSetFlags;
    logic [7:0] hwSetAcq;
    logic [6:0] hwSetDisp;
    logic [1:0] pinActive;
    logic [1:0] pinFall;
    logic [6:0] rawRise;
    logic readClear;
    wrHit = busReq.wr;
    takeAck = coreAck & state_reg.present.valid;
    state_next = state_reg;
    pinActive = ~events.extPinN;
    pinFall = pinActive & ~state_reg.pinPrev;
    hwSetFlags = 7'h00;
    hwSetAcq = 8'h00;
    hwSetDisp = 7'h00;
    rawRise = 7'h00;
    readClear = 1'b0;

    // hardware set sources, or-ed in after any write so a set is never lost
    hwSetFlags[FLG_EXT0] = state_reg.extMode[0] & pinFall[0];
    hwSetFlags[FLG_EXT1] = state_reg.extMode[1] & pinFall[1];
    hwSetFlags[FLG_TMR0] = events.timerOverflow[0];
    hwSetFlags[FLG_TMR1] = events.timerOverflow[1];
    hwSetFlags[FLG_RX] = events.serialRxDone;
    hwSetFlags[FLG_TX] = events.serialTxDone;
    hwSetFlags[FLG_ADC] = events.adcDone;
    hwSetDisp[DSP_H_FLAG] = events.dispSync[0];
    hwSetDisp[DSP_V_FLAG] = events.dispSync[1];
    hwSetAcq[ACQ_H_FLAG] = events.acqSync[0];
    hwSetAcq[ACQ_V_FLAG] = events.acqSync[1];
    hwSetAcq[ACQ_L24_FLAG] = events.acqSync[2];
    hwSetAcq[ACQ_EVEN_FLAG] = events.acqSync[3];

    // register writes
    if (wrHit) begin
      unique case (busReq.addr)
        ADDR_IRQ_ENABLE: state_next.irqEnable = busReq.wdata;
        ADDR_PRIO_LOW: state_next.prioLow = busReq.wdata[6:0];
        ADDR_PRIO_HIGH: state_next.prioHigh = busReq.wdata[6:0];
        ADDR_REQ_FLAGS: state_next.reqFlags = busReq.wdata[6:0];
        ADDR_EXT_MODE: state_next.extMode = busReq.wdata[1:0];
        ADDR_EVT_MASK: state_next.evtMask = busReq.wdata[6:0];
        ADDR_ACQ_SYNC: state_next.acqSync = busReq.wdata;
        ADDR_DISP_SYNC: state_next.dispSync = busReq.wdata[6:0];
        default: ;
      endcase
    end

    // acknowledge clears edge-type external and timer flags, like hardware service
    if (takeAck) begin
      unique case (state_reg.present.source)
        3'(SRC_EXT0): begin
          if (state_reg.extMode[0]) begin
            state_next.reqFlags[FLG_EXT0] = 1'b0;
          end
        end
        3'(SRC_EXT1): begin
          if (state_reg.extMode[1]) begin
            state_next.reqFlags[FLG_EXT1] = 1'b0;
          end
        end
        3'(SRC_TMR0): state_next.reqFlags[FLG_TMR0] = 1'b0;
        3'(SRC_TMR1): state_next.reqFlags[FLG_TMR1] = 1'b0;
        default: ;
      endcase
    end

    state_next.reqFlags = state_next.reqFlags | hwSetFlags;
    state_next.acqSync = state_next.acqSync | hwSetAcq;
    state_next.dispSync = state_next.dispSync | hwSetDisp;

    // level mode: the flag simply follows the active-low pin
    for (int p = 0; p < 2; p++) begin
      if (!state_reg.extMode[p]) begin
        state_next.reqFlags[2*p] = pinActive[p];
      end
    end
    state_next.pinPrev = pinActive;

    // nesting: ack pushes the taken level, return pops the highest one
    if (coreReti && svcActive) begin
      state_next.inService[svcLevel] = 1'b0;
    end
    if (takeAck) begin
      state_next.inService[state_reg.present.level] = 1'b1;
    end

    // sticky event status: rising raw requests, read clears, set wins
    rawRise = rawReq & ~state_reg.rawPrev;
    state_next.rawPrev = rawReq;
    readClear = busReq.rd && busReq.addr == ADDR_EVT_STATUS;
    state_next.evtStatus = (readClear ? 7'h00 : state_reg.evtStatus) | rawRise;

    // response delay: hold a new winner back for the least response time
    if (!candValid || takeAck) begin
      state_next.delayCnt = '0;
    end else if (state_reg.delayCnt != RESP_MIN) begin
      state_next.delayCnt = state_reg.delayCnt + CNT_W'(1);
    end
    state_next.present.valid = candValid && !takeAck
      && state_reg.delayCnt == RESP_MIN;
    state_next.present.source = candSrc;
    state_next.present.level = candLevel;
    state_next.present.vector = VEC_BASE + 8'({candSrc, VEC_SHIFT'(0)});

    // read data, valid in the cycle after the strobe; unmapped reads give zero
    state_next.rdData = 8'h00;
    if (busReq.rd) begin
      unique case (busReq.addr)
        ADDR_IRQ_ENABLE: state_next.rdData = state_reg.irqEnable;
        ADDR_PRIO_LOW: state_next.rdData = {1'b0, state_reg.prioLow};
        ADDR_PRIO_HIGH: state_next.rdData = {1'b0, state_reg.prioHigh};
        ADDR_REQ_FLAGS: state_next.rdData = {1'b0, state_reg.reqFlags};
        ADDR_EXT_MODE: state_next.rdData = {6'h00, state_reg.extMode};
        ADDR_EVT_STATUS: state_next.rdData = {1'b0, state_reg.evtStatus};
        ADDR_EVT_MASK: state_next.rdData = {1'b0, state_reg.evtMask};
        ADDR_ACQ_SYNC: state_next.rdData = state_reg.acqSync;
        ADDR_DISP_SYNC: state_next.rdData = {1'b0, state_reg.dispSync};
        ADDR_IN_SERVICE: state_next.rdData = {4'h0, state_reg.inService};
        default: state_next.rdData = 8'h00;
      endcase
    end
  end

  // single state register; reset loads constants only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg.irqEnable <= RST_IRQ_ENABLE;
      state_reg.prioLow <= RST_PRIO;
      state_reg.prioHigh <= RST_PRIO;
      state_reg.reqFlags <= RST_REQ_FLAGS;
      state_reg.extMode <= RST_EXT_MODE;
      state_reg.evtStatus <= RST_EVT;
      state_reg.evtMask <= RST_EVT;
      state_reg.acqSync <= RST_ACQ_SYNC;
      state_reg.dispSync <= RST_DISP_SYNC;
      state_reg.inService <= 4'h0;
      state_reg.pinPrev <= 2'h0;
      state_reg.rawPrev <= 7'h00;
      state_reg.delayCnt <= '0;
      state_reg.rdData <= 8'h00;
      state_reg.present <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flops, interrupt level from status and mask
  assign busRdata = state_reg.rdData;
  assign coreReq = state_reg.present;
  assign irqOut = |(state_reg.evtStatus & state_reg.evtMask);

endmodule

`default_nettype wire

// ### design/spiu_pkg.sv
// spiu_pkg: constants and carrier types for the seven-source priority interrupt unit
// assumes one 25 MHz core clock and an 8-bit register port with one-cycle read data
package spiu_pkg;

  // register offsets on the 8-bit register port
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'ha8;
  localparam logic [7:0] ADDR_PRIO_LOW = 8'ha9;
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'haa;
  localparam logic [7:0] ADDR_REQ_FLAGS = 8'hb8;
  localparam logic [7:0] ADDR_EXT_MODE = 8'hb9;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'hba;
  localparam logic [7:0] ADDR_EVT_MASK = 8'hbb;
  localparam logic [7:0] ADDR_ACQ_SYNC = 8'hc0;
  localparam logic [7:0] ADDR_DISP_SYNC = 8'hc8;
  localparam logic [7:0] ADDR_IN_SERVICE = 8'hbc;

  // reset values
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [6:0] RST_PRIO = 7'h00;
  localparam logic [6:0] RST_REQ_FLAGS = 7'h00;
  localparam logic [1:0] RST_EXT_MODE = 2'h0;
  localparam logic [6:0] RST_EVT = 7'h00;
  localparam logic [7:0] RST_ACQ_SYNC = 8'h00;
  localparam logic [6:0] RST_DISP_SYNC = 7'h00;

  // source indices, also bit positions in enable and priority registers
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_SER = 4;
  localparam int SRC_SYNC = 5;
  localparam int SRC_ADC = 6;
  localparam int NUM_SRC = 7;
  localparam int GLOBAL_EN_BIT = 7;

  // request flag register layout
  localparam int FLG_EXT0 = 0;
  localparam int FLG_TMR0 = 1;
  localparam int FLG_EXT1 = 2;
  localparam int FLG_TMR1 = 3;
  localparam int FLG_RX = 4;
  localparam int FLG_TX = 5;
  localparam int FLG_ADC = 6;

  // display sync register: flag/enable pairs in bits 3..0, plain bits above
  localparam int DSP_H_FLAG = 0;
  localparam int DSP_H_EN = 1;
  localparam int DSP_V_FLAG = 2;
  localparam int DSP_V_EN = 3;
  // acquisition sync register: flag at even bit, enable at odd bit above it
  localparam int ACQ_H_FLAG = 0;
  localparam int ACQ_V_FLAG = 2;
  localparam int ACQ_L24_FLAG = 4;
  localparam int ACQ_EVEN_FLAG = 6;

  // vectors: 03, 0b, 13, ... one step of eight per source
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam int VEC_SHIFT = 3;

  // response delay window, scaled to this clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESP_MIN_NS = 890;
  localparam int RESP_MAX_NS = 2330;
  localparam int RESP_MIN_CYC = (RESP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESP_MAX_CYC = RESP_MAX_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spiu_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic [1:0] level;
    logic [2:0] source;
  } spiu_core_req_t;

  typedef struct packed {
    logic [1:0] extPinN;
    logic [1:0] timerOverflow;
    logic serialRxDone;
    logic serialTxDone;
    logic adcDone;
    logic [1:0] dispSync;
    logic [3:0] acqSync;
  } spiu_events_t;

endpackage

// ### bench/spiu_props.sv
// spiu_props: port-level assertions for the interrupt unit
// assumes it is bound to spiu_controller and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none

module spiu_props
  import spiu_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire spiu_bus_req_t busReq,
  input wire logic [7:0] busRdata,
  input wire spiu_events_t events,
  input wire spiu_core_req_t coreReq,
  input wire logic coreAck,
  input wire logic coreReti,
  input wire logic irqOut
);
  logic [7:0] ie, pl, ph, mk;
  logic [3:0] svc;
  logic [2:0] top;
  logic take, ge;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  assign take = coreReq.valid && coreAck;
  assign ge = ie[7];

  // highest level in service plus one, zero when idle
  always_comb begin
    top = 3'h0;
    for (int k = 0; k < 4; k++) if (svc[k]) top = 3'(k + 1);
  end

  // shadows rebuilt from port traffic; reti pops before ack pushes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ie <= 8'h00;
      pl <= 8'h00;
      ph <= 8'h00;
      mk <= 8'h00;
      svc <= 4'h0;
    end else begin
      if (busReq.wr && busReq.addr == ADDR_IRQ_ENABLE) ie <= busReq.wdata;
      if (busReq.wr && busReq.addr == ADDR_PRIO_LOW) pl <= busReq.wdata;
      if (busReq.wr && busReq.addr == ADDR_PRIO_HIGH) ph <= busReq.wdata;
      if (busReq.wr && busReq.addr == ADDR_EVT_MASK) mk <= busReq.wdata;
      svc <= ((coreReti && top != 3'h0) ? svc & ~(4'h1 << (top - 3'h1)) : svc)
        | (take ? 4'h1 << coreReq.level : 4'h0);
    end
  end

  a_vec_map: assert property (coreReq.valid |->
    coreReq.vector == VEC_BASE + {2'h0, coreReq.source, 3'h0})
    else $error("vector does not match source");
  a_ack_drop: assert property (take |=> !coreReq.valid)
    else $error("request still shown after ack");
  a_ack_gap: assert property (take |=> !coreReq.valid [*8] ##1
    !coreReq.valid [*8] ##1 !coreReq.valid [*7])
    else $error("next request shown too soon");
  a_global_off: assert property ($fell(ge) |=> !coreReq.valid [*8])
    else $error("request shown with global enable off");
  a_src_enable: assert property (coreReq.valid && ie == $past(ie) &&
    ie == $past(ie, 2) |-> ie[7] && ie[coreReq.source])
    else $error("request from a disabled source");
  a_prio_level: assert property (coreReq.valid && pl == $past(pl) &&
    ph == $past(ph) |-> coreReq.level == {ph[coreReq.source], pl[coreReq.source]})
    else $error("level differs from programmed priority");
  a_nest_level: assert property (coreReq.valid && top != 3'h0 |->
    {1'b0, coreReq.level} >= top)
    else $error("request not above level in service");
  a_irq_masked: assert property (irqOut |-> mk != 8'h00)
    else $error("interrupt out with all events masked");

  c_adc_taken: cover property (take && coreReq.vector == 8'h33);
  c_nested: cover property (take && svc != 4'h0);
  c_irq_rise: cover property ($rose(irqOut));
endmodule

`default_nettype wire

// ### bench/spiu_core_model.sv
// spiu_core_model: processor core side, acks presented requests, ends routines
// assumes the bench sets the ack wait and pulses retiGo for a routine end
`timescale 1ns/1ps
`default_nettype none

module spiu_core_model
  import spiu_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire spiu_core_req_t coreReq,
  input wire logic [3:0] ackWait,
  input wire logic retiGo,
  output logic coreAck,
  output logic coreReti,
  output logic [7:0] lastVec,
  output logic [7:0] ackCount
);
  logic [3:0] waitCnt;

  // a slow core lets a request stand; the vector counts only if still valid
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      coreAck <= 1'b0;
      coreReti <= 1'b0;
      lastVec <= 8'h00;
      ackCount <= 8'h00;
      waitCnt <= 4'h0;
    end else begin
      coreReti <= retiGo;
      coreAck <= 1'b0;
      waitCnt <= 4'h0;
      if (coreReq.valid && !coreAck && waitCnt >= ackWait) coreAck <= 1'b1;
      else if (coreReq.valid && !coreAck) waitCnt <= waitCnt + 4'h1;
      if (coreAck && coreReq.valid) begin
        lastVec <= coreReq.vector;
        ackCount <= ackCount + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// ### bench/spiu_controller_test.sv
// spiu_controller_test: register, vector, gating, nesting and event tests
// assumes the core model answers the core link; one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none

module spiu_controller_test
  import spiu_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic retiGo = 1'b0;
  logic [3:0] ackWait = 4'h0;
  spiu_bus_req_t busReq = '0;
  spiu_events_t events = '{extPinN: 2'h3, default: '0};
  logic [7:0] busRdata, lastVec, ackCount, rdv, acks0;
  spiu_core_req_t coreReq;
  logic coreAck, coreReti, irqOut;
  int errTotal = 0;
  int testsRun = 0;
  int cyc = 0;
  int n;
  logic [7:0] regs [11] = '{ADDR_IRQ_ENABLE, ADDR_PRIO_LOW, ADDR_PRIO_HIGH, ADDR_REQ_FLAGS,
    ADDR_EXT_MODE, ADDR_EVT_STATUS, ADDR_EVT_MASK, ADDR_IN_SERVICE, ADDR_ACQ_SYNC,
    ADDR_DISP_SYNC, 8'h00};

  always #20 clk = ~clk;

  spiu_controller dut (.clk(clk), .reset_n(reset_n), .busReq(busReq), .busRdata(busRdata),
    .events(events), .coreReq(coreReq), .coreAck(coreAck), .coreReti(coreReti),
    .irqOut(irqOut));
  spiu_core_model core (.clk(clk), .reset_n(reset_n), .coreReq(coreReq), .ackWait(ackWait),
    .retiGo(retiGo), .coreAck(coreAck), .coreReti(coreReti), .lastVec(lastVec),
    .ackCount(ackCount));

  // ceiling well above the thousand or so cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errTotal++;
      testDone();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    @(negedge clk);
    rdv = busRdata;
  endtask

  // n ends at 80 when no request was taken
  task automatic waitAck();
    acks0 = ackCount;
    for (n = 0; n < 80 && ackCount === acks0; n++) @(posedge clk);
  endtask

  task automatic reti();
    @(posedge clk);
    retiGo <= 1'b1;
    @(posedge clk);
    retiGo <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // external pins stay low until released; others pulse one cycle
  task automatic pulse(input int s);
    @(posedge clk);
    case (s)
      1: events.timerOverflow[0] <= 1'b1;
      3: events.timerOverflow[1] <= 1'b1;
      4: events.serialRxDone <= 1'b1;
      5: events.dispSync[0] <= 1'b1;
      default: events.extPinN[s / 2] <= 1'b0;
    endcase
    @(posedge clk);
    events <= '{extPinN: events.extPinN, default: '0};
  endtask

  task automatic testDone();
    if (errTotal == 0 && testsRun > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    foreach (regs[k]) begin
      rd(regs[k]);
      check(rdv, 8'h00, "reset value");
    end
    wr(ADDR_DISP_SYNC, 8'hff);
    rd(ADDR_DISP_SYNC);
    check(rdv, 8'h7f, "display sync write");
    wr(ADDR_ACQ_SYNC, 8'h55);
    rd(ADDR_ACQ_SYNC);
    check(rdv, 8'h55, "acquisition sync write");
    wr(ADDR_ACQ_SYNC, 8'h00);
    // every source alone, odd sources acked slowly
    for (int i = 0; i < 7; i++) begin
      ackWait <= 4'(i % 2 * 6);
      wr(ADDR_IRQ_ENABLE, 8'h80 | (8'h01 << i));
      wr(ADDR_DISP_SYNC, 8'h02);
      if (i == 6) wr(ADDR_REQ_FLAGS, 8'h40);
      else pulse(i);
      waitAck();
      check(8'(n >= RESP_MIN_CYC && n <= RESP_MAX_CYC), 8'h01, "response time");
      check(lastVec, 8'h03 + 8'(8 * i), "vector");
      wr(ADDR_REQ_FLAGS, 8'h00);
      wr(ADDR_DISP_SYNC, 8'h00);
      events.extPinN <= 2'h3;
      reti();
    end
    // falling-edge mode on pin one: ack clears the flag although the pin stays low
    wr(ADDR_EXT_MODE, 8'h02);
    wr(ADDR_IRQ_ENABLE, 8'h84);
    pulse(2);
    waitAck();
    check(lastVec, 8'h13, "edge mode taken");
    reti();
    waitAck();
    check(8'(n), 8'h50, "edge mode no repeat");
    events.extPinN <= 2'h3;
    wr(ADDR_EXT_MODE, 8'h00);
    // sync group through the even-field acquisition pair
    wr(ADDR_IRQ_ENABLE, 8'ha0);
    wr(ADDR_ACQ_SYNC, 8'h80);
    @(posedge clk);
    events.acqSync[3] <= 1'b1;
    @(posedge clk);
    events.acqSync[3] <= 1'b0;
    waitAck();
    check(lastVec, 8'h2b, "acquisition sync");
    wr(ADDR_ACQ_SYNC, 8'h00);
    reti();
    // global bit off holds an enabled source back
    wr(ADDR_IRQ_ENABLE, 8'h02);
    pulse(1);
    waitAck();
    check(8'(n), 8'h50, "global off");
    wr(ADDR_IRQ_ENABLE, 8'h82);
    waitAck();
    check(lastVec, 8'h0b, "global on");
    reti();
    // a disabled source pends, then a software clear cancels it
    wr(ADDR_IRQ_ENABLE, 8'h88);
    pulse(1);
    waitAck();
    check(8'(n), 8'h50, "source disabled");
    wr(ADDR_REQ_FLAGS, 8'h00);
    wr(ADDR_IRQ_ENABLE, 8'h82);
    waitAck();
    check(8'(n), 8'h50, "request cancelled");
    // timers at level 1, serial at level 2
    wr(ADDR_PRIO_LOW, 8'h0a);
    wr(ADDR_PRIO_HIGH, 8'h10);
    wr(ADDR_IRQ_ENABLE, 8'h9a);
    pulse(1);
    waitAck();
    check(lastVec, 8'h0b, "level one taken");
    pulse(3);
    waitAck();
    check(8'(n), 8'h50, "equal level held");
    pulse(4);
    waitAck();
    check(lastVec, 8'h23, "higher level nests");
    rd(ADDR_IN_SERVICE);
    check(rdv, 8'h06, "levels in service");
    wr(ADDR_REQ_FLAGS, 8'h08);
    reti();
    reti();
    waitAck();
    check(lastVec, 8'h1b, "held source after return");
    reti();
    // only timer 0 is masked in, a status read clears it
    wr(ADDR_IRQ_ENABLE, 8'h00);
    wr(ADDR_EVT_MASK, 8'h02);
    rd(ADDR_EVT_STATUS);
    pulse(3);
    repeat (2) @(negedge clk);
    check(8'(irqOut), 8'h00, "irq masked out");
    pulse(1);
    repeat (2) @(negedge clk);
    check(8'(irqOut), 8'h01, "irq raised");
    rd(ADDR_EVT_STATUS);
    check(rdv, 8'h0a, "event status");
    check(8'(irqOut), 8'h00, "irq cleared by read");
    @(negedge clk);
    check(busRdata, 8'h00, "read data one cycle");
    testDone();
  end
endmodule

bind spiu_controller spiu_props props (.clk(clk), .reset_n(reset_n), .busReq(busReq),
  .busRdata(busRdata), .events(events), .coreReq(coreReq), .coreAck(coreAck),
  .coreReti(coreReti), .irqOut(irqOut));

`default_nettype wire
